// File: hdl/nvm_loader.sv
/*
 * walks the one-time-programmable words after reset and hands each to
 * the register file; assumes the memory answers on the next cycle.
 */
module nvm_loader
   import regbank_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_rst,
   output logic [1:0]      o_nvm_addr,   // word requested from memory
   input  wire logic [7:0] i_nvm_data,   // word returned one cycle later
   output logic            o_load,       // word valid for the register file
   output logic [1:0]      o_load_idx,   // which word is valid
   output logic [7:0]      o_load_data,  // its value
   output logic            o_done        // configuration read finished
);
   logic [2:0] cnt_q;   // words requested so far
   logic       pend_q;  // a request awaits its answer
   logic [1:0] idx_q;   // index of the pending request

   // request counter runs once per reset
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cnt_q  <= 3'h0;
         pend_q <= 1'b0;
         idx_q  <= 2'h0;
      end else begin
         pend_q <= (cnt_q < 3'(NVM_WORDS));
         idx_q  <= cnt_q[1:0];
         if (cnt_q < 3'(NVM_WORDS)) begin
            cnt_q <= cnt_q + 3'h1;
         end
      end
   end

   // answer is registered so data outputs come from flip-flops
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_load      <= 1'b0;
         o_load_idx  <= 2'h0;
         o_load_data <= 8'h00;
      end else begin
         o_load      <= pend_q;
         o_load_idx  <= idx_q;
         o_load_data <= i_nvm_data;
      end
   end

   assign o_nvm_addr = cnt_q[1:0];
   assign o_done     = (cnt_q == 3'(NVM_WORDS)) && !pend_q && !o_load;
endmodule : nvm_loader

// File: hdl/rail_regbank.sv
/*
 * register bank of a dual step-down regulator controller, reached over
 * a two-wire serial bus. assumes synchronous scl/sda samples, an nvm
 * that answers one cycle after its address, and the rail 0 enable pin.
 */
// Operation
// - mode bit 3 selects forced pulse width
// - bit 2 connects discharge, resets to one
// - bit 1 gates rail with enable pin
// - bit 0 is the software rail enable
// - limit code bits 5:3, codes 6,7 reserved
// - ramp code bits 2:0, codes 0,1 reserved
// - offset one holds read only nvm version
// - variable fields load from nvm at start
// - target 0x61, then index, then data
// - writes advance index, reads do not
module rail_regbank
   import regbank_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_rst,
   input  wire logic       i_scl,         // serial clock sample
   input  wire logic       i_sda,         // serial data sample
   output logic            o_sda,         // serial data out value
   output logic            o_sda_oe,      // high while pulling sda low
   input  wire logic       i_rail0_en_pin,// external enable pin
   output logic [1:0]      o_nvm_addr,    // nvm word address
   input  wire logic [7:0] i_nvm_data,    // nvm word data
   output logic            o_config_done, // configuration read complete
   output rail_ctrl_t      o_rail0,       // rail 0 controls
   input  wire logic [7:0] i_status_top,  // live top status
   input  wire logic [7:0] i_status_rail, // live rail status
   input  wire logic [7:0] i_load_low,    // measured load current low
   input  wire logic [7:0] i_load_high    // measured load current high
);
   reg_access_t acc;              // byte access from the serial end
   logic [7:0]  rdata;            // byte at current index
   logic        ld;               // nvm word strobe
   logic [1:0]  ld_idx;
   logic [7:0]  ld_data;
   logic        done;

   logic [1:0]  ident_q;          // part identity field
   logic [7:0]  nvm_ver_q;        // nvm version
   logic [7:0]  mode_q;           // rail 0 mode and enable byte
   logic [7:0]  limit_q;          // rail 0 limit and slew byte
   logic [7:0]  gen_q [0:19];     // plain bytes of the map, the first 16 read/write, the rest read only

   // offsets of plain bytes, read/write ones first, stored in gen_q by position
   localparam logic [7:0] GEN_OFS [0:19] = '{
      OFS_RAIL1_DELAYS, OFS_OUT1_DELAYS, OFS_OUT2_DELAYS, OFS_GPO_CONTROL,
      OFS_GLOBAL, OFS_SYNC_LOOP, OFS_PG_SETUP_A, OFS_PG_SETUP_B,
      OFS_SOFT_RESET, OFS_TOP_FLAGS_A, OFS_TOP_FLAGS_B, OFS_RAIL_FLAGS,
      OFS_TOP_MASKS_A, OFS_TOP_MASKS_B, OFS_RAIL_MASKS, OFS_LOAD_SELECT,
      OFS_PG_FAULTS, OFS_TOP_STATUS, OFS_RAIL_STATUS, OFS_LOAD_HIGH
   };
   localparam int GEN_RW = 16;    // first 16 entries are writable

   // serial bus target
   serial_target u_link (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_scl   (i_scl),
      .i_sda   (i_sda),
      .o_sda   (o_sda),
      .o_sda_oe(o_sda_oe),
      .o_acc   (acc),
      .i_rdata (rdata)
   );

   // configuration read from nvm after reset
   nvm_loader u_nvm (
      .i_mclk     (i_mclk),
      .i_rst      (i_rst),
      .o_nvm_addr (o_nvm_addr),
      .i_nvm_data (i_nvm_data),
      .o_load     (ld),
      .o_load_idx (ld_idx),
      .o_load_data(ld_data),
      .o_done     (done)
   );

   assign o_config_done = done;

   // identity and version take only nvm values, never host writes
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         ident_q   <= 2'h0;
         nvm_ver_q <= RST_ZERO;
      end else if (ld && ld_idx == NVM_IDX_IDENT) begin
         ident_q   <= PART_IDENTITY ^ ld_data[1:0];
      end else if (ld && ld_idx == NVM_IDX_VERSION) begin
         nvm_ver_q <= ld_data;
      end
   end

   // rail 0 mode byte: nvm preset, then host writes
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         mode_q <= RST_RAIL0_MODE;                    // discharge on
      end else if (ld && ld_idx == NVM_IDX_MODE) begin
         // variable bits from nvm, discharge keeps its fixed one
         mode_q <= {4'h0, ld_data[3], 1'b1, ld_data[1:0]};
      end else if (acc.wr && acc.index == OFS_RAIL0_MODE) begin
         mode_q <= acc.data & MASK_FULL;
      end
   end

   // rail 0 limit byte: writable while the rail runs
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         limit_q <= RST_ZERO;
      end else if (ld && ld_idx == NVM_IDX_LIMIT) begin
         limit_q <= {2'h0, ld_data[5:0]};
      end else if (acc.wr && acc.index == OFS_RAIL0_LIMIT) begin
         limit_q <= acc.data;
      end
   end

   // remaining map bytes except load low, one storage slot each
   genvar g;
   generate
      for (g = 0; g < 20; g++) begin : gen_bytes
         always_ff @(posedge i_mclk) begin
            if (i_rst) begin
               gen_q[g] <= RST_ZERO;
            end else if (g >= GEN_RW) begin
               // read-only values captured each cycle; the pg faults entry is held at zero
               case (g)
                  17: gen_q[g] <= i_status_top;
                  18: gen_q[g] <= i_status_rail;
                  19: gen_q[g] <= i_load_high;
                  default: gen_q[g] <= RST_ZERO;
               endcase
            end else if (acc.wr && acc.index == GEN_OFS[g]) begin
               gen_q[g] <= acc.data;
            end
         end
      end
   endgenerate

   // read multiplexer; unmapped indexes read zero
   always_comb begin
      rdata = RST_ZERO;
      if (acc.index == OFS_IDENTITY) begin
         rdata = {ident_q, RST_IDENT_LOW[5:0]};
      end else if (acc.index == OFS_NVM_VERSION) begin
         rdata = nvm_ver_q;
      end else if (acc.index == OFS_RAIL0_MODE) begin
         rdata = mode_q;
      end else if (acc.index == OFS_RAIL0_LIMIT) begin
         rdata = limit_q;
      end else if (acc.index == OFS_LOAD_LOW) begin
         rdata = i_load_low;
      end else begin
         for (int k = 0; k < 20; k++) begin
            if (acc.index == GEN_OFS[k]) begin
               rdata = gen_q[k];
            end
         end
      end
   end

   // rail 0 outputs; a reserved code is passed on unchanged since the
   // power stage decides how to treat it
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_rail0 <= '0;
      end else begin
         o_rail0.forced_pwm   <= mode_q[POS_FORCED_PWM];
         o_rail0.discharge_on <= mode_q[POS_DISCHARGE];
         o_rail0.run          <= done && mode_q[POS_SOFT_ENABLE] &&
            (!mode_q[POS_PIN_GATING] || i_rail0_en_pin);
         o_rail0.limit_code   <= limit_q[POS_ILIM_LSB +: 3];
         o_rail0.ramp_code    <= limit_q[POS_RAMP_LSB +: 3];
      end
   end

   // assertions
   run_gate_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (done && mode_q[0] && mode_q[1] && !i_rail0_en_pin) |=> !o_rail0.run)
      else $error("rail ran with pin low under gating");
   run_soft_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (done && mode_q[0] && !mode_q[1]) |=> o_rail0.run)
      else $error("rail not running with soft enable");
   run_off_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      !mode_q[0] |=> !o_rail0.run)
      else $error("rail running while disabled");
   pwm_follow_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      o_rail0.forced_pwm == $past(mode_q[3]))
      else $error("forced mode output wrong");
   dis_reset_a: assert property (@(posedge i_mclk)
      i_rst |=> mode_q[2])
      else $error("discharge not set after reset");
   limit_write_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (acc.wr && acc.index == OFS_RAIL0_LIMIT && !ld) |=> ##1
         o_rail0.limit_code == $past(acc.data[5:3], 2))
      else $error("limit code not applied");
   ramp_write_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (acc.wr && acc.index == OFS_RAIL0_LIMIT && !ld) |=> ##1
         o_rail0.ramp_code == $past(acc.data[2:0], 2))
      else $error("ramp code not applied");
   ident_ro_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (acc.wr && !ld) |=> $stable(ident_q) && $stable(nvm_ver_q))
      else $error("identity changed by write");
   ver_load_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (ld && ld_idx == NVM_IDX_VERSION) |=> nvm_ver_q == $past(ld_data))
      else $error("version not loaded from nvm");
   cfg_done_a: assert property (@(posedge i_mclk)
      $fell(i_rst) |-> ##[1:8] done)
      else $error("configuration read too slow");
   idx_inc_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      acc.wr |=> acc.index == $past(acc.index) + 8'h01)
      else $error("index did not advance");
   write_cv: cover property (@(posedge i_mclk) acc.wr);
   two_write_cv: cover property (@(posedge i_mclk) acc.wr ##[1:300] acc.wr);
   run_cv: cover property (@(posedge i_mclk) $rose(o_rail0.run));
endmodule : rail_regbank

// File: hdl/regbank_pkg.sv
/*
 * shared constants and types of the dual rail register bank.
 * assumes one clock domain and a synchronous, active high reset.
 */
package regbank_pkg;
   // serial target address
   localparam logic [6:0] TARGET_ADDR        = 7'h61;
   // register offsets
   localparam logic [7:0] OFS_IDENTITY       = 8'h00;
   localparam logic [7:0] OFS_NVM_VERSION    = 8'h01;
   localparam logic [7:0] OFS_RAIL0_MODE     = 8'h02;
   localparam logic [7:0] OFS_RAIL0_LIMIT    = 8'h03;
   localparam logic [7:0] OFS_RAIL1_DELAYS   = 8'h0d;
   localparam logic [7:0] OFS_OUT1_DELAYS    = 8'h10;
   localparam logic [7:0] OFS_OUT2_DELAYS    = 8'h11;
   localparam logic [7:0] OFS_GPO_CONTROL    = 8'h12;
   localparam logic [7:0] OFS_GLOBAL         = 8'h13;
   localparam logic [7:0] OFS_SYNC_LOOP      = 8'h14;
   localparam logic [7:0] OFS_PG_SETUP_A     = 8'h15;
   localparam logic [7:0] OFS_PG_SETUP_B     = 8'h16;
   localparam logic [7:0] OFS_PG_FAULTS      = 8'h17;
   localparam logic [7:0] OFS_SOFT_RESET     = 8'h18;
   localparam logic [7:0] OFS_TOP_FLAGS_A    = 8'h19;
   localparam logic [7:0] OFS_TOP_FLAGS_B    = 8'h1a;
   localparam logic [7:0] OFS_RAIL_FLAGS     = 8'h1b;
   localparam logic [7:0] OFS_TOP_STATUS     = 8'h1d;
   localparam logic [7:0] OFS_RAIL_STATUS    = 8'h1e;
   localparam logic [7:0] OFS_TOP_MASKS_A    = 8'h20;
   localparam logic [7:0] OFS_TOP_MASKS_B    = 8'h21;
   localparam logic [7:0] OFS_RAIL_MASKS     = 8'h22;
   localparam logic [7:0] OFS_LOAD_SELECT    = 8'h24;
   localparam logic [7:0] OFS_LOAD_HIGH      = 8'h25;
   localparam logic [7:0] OFS_LOAD_LOW       = 8'h26;
   // field positions of rail 0 mode byte
   localparam int POS_FORCED_PWM  = 3;
   localparam int POS_DISCHARGE   = 2;
   localparam int POS_PIN_GATING  = 1;
   localparam int POS_SOFT_ENABLE = 0;
   // field positions of rail 0 limit byte
   localparam int POS_ILIM_LSB    = 3;
   localparam int POS_RAMP_LSB    = 0;
   // identity field sits in bits 7:6
   localparam int POS_IDENT_LSB   = 6;
   // reset values
   localparam logic [7:0] RST_RAIL0_MODE     = 8'h04;
   localparam logic [7:0] RST_IDENT_LOW      = 8'h15;   // arbitrary value
   localparam logic [1:0] PART_IDENTITY      = 2'h1;   // arbitrary value
   localparam logic [7:0] RST_ZERO           = 8'h00;
   // writable mask of rail 0 mode byte: bits 7:4 reserved, stored anyway
   localparam logic [7:0] MASK_FULL          = 8'hff;
   // highest legal limit code, lowest legal ramp code
   localparam logic [2:0] ILIM_MAX_CODE      = 3'h5;
   localparam logic [2:0] RAMP_MIN_CODE      = 3'h2;
   // count of nvm loaded bytes
   localparam int NVM_WORDS = 4;
   localparam logic [1:0] NVM_IDX_VERSION    = 2'h0;
   localparam logic [1:0] NVM_IDX_MODE       = 2'h1;
   localparam logic [1:0] NVM_IDX_LIMIT      = 2'h2;
   localparam logic [1:0] NVM_IDX_IDENT      = 2'h3;

   // serial front end states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_INDEX = 3'b010,
      ST_WDATA = 3'b011,
      ST_RDATA = 3'b100,
      ST_SKIP  = 3'b101
   } link_state_t;

   // one byte access handed from the serial end to the register file
   typedef struct packed {
      logic       wr;     // write strobe
      logic [7:0] index;  // register index
      logic [7:0] data;   // write data
   } reg_access_t;

   // rail 0 controls steering the power stage
   typedef struct packed {
      logic       forced_pwm;
      logic       discharge_on;
      logic       run;
      logic [2:0] limit_code;
      logic [2:0] ramp_code;
   } rail_ctrl_t;
endpackage : regbank_pkg

// File: hdl/serial_target.sv
/*
 * byte level serial target: start/stop, address match, index, data.
 * assumes scl and sda inputs already synchronous to i_mclk.
 */
module serial_target
   import regbank_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_rst,
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda,
   output logic            o_sda_oe,     // high while pulling sda low for ack or a zero data bit
   output reg_access_t     o_acc,        // write strobe, index, data
   input  wire logic [7:0] i_rdata       // byte at current index
);
   link_state_t st_q;
   logic       scl_q, sda_q;   // previous samples for edge finding
   logic [7:0] sh_q;           // shift register
   logic [3:0] bit_q;          // bit count inside a byte, 8 is ack slot
   logic [7:0] idx_q;          // register index
   logic       ack_q;          // pulling sda low for acknowledge
   logic       tx_q;           // driving read data
   logic [7:0] txb_q;          // byte being sent
   logic       wr_q;
   logic [7:0] wd_q;

   wire rise  = i_scl && !scl_q;
   wire fall  = !i_scl && scl_q;
   wire start = scl_q && i_scl && sda_q && !i_sda;
   wire stop  = scl_q && i_scl && !sda_q && i_sda;

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= i_scl;
         sda_q <= i_sda;
      end
   end

   // byte framing and protocol state
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st_q  <= ST_IDLE;
         sh_q  <= 8'h00;
         bit_q <= 4'h0;
         idx_q <= 8'h00;
         ack_q <= 1'b0;
         tx_q  <= 1'b0;
         txb_q <= 8'h00;
         wr_q  <= 1'b0;
         wd_q  <= 8'h00;
      end else begin
         wr_q <= 1'b0;
         if (start) begin                 // repeated start is equal to start
            st_q  <= ST_ADDR;
            // the scl fall that follows start is no bit; it wraps this to 0
            bit_q <= 4'hf;
            ack_q <= 1'b0;
            tx_q  <= 1'b0;
         end else if (stop) begin
            st_q  <= ST_IDLE;
            ack_q <= 1'b0;
            tx_q  <= 1'b0;
         end else if (rise && bit_q < 4'h8) begin
            sh_q <= {sh_q[6:0], i_sda};
         end else if (rise && st_q == ST_RDATA) begin
            if (!i_sda) begin
               txb_q <= i_rdata;          // host acked, send same index again
            end else begin
               st_q <= ST_SKIP;           // no ack ends the read, sda stays released
            end
         end else if (fall) begin
            if (bit_q == 4'h7) begin
               bit_q <= 4'h8;
               tx_q  <= 1'b0;
               case (st_q)
                  ST_ADDR: begin
                     ack_q <= (sh_q[7:1] == TARGET_ADDR);
                  end
                  ST_INDEX, ST_WDATA: begin
                     ack_q <= 1'b1;
                  end
                  default: begin
                     ack_q <= 1'b0;
                  end
               endcase
            end else if (bit_q == 4'h8) begin
               bit_q <= 4'h0;
               ack_q <= 1'b0;
               case (st_q)
                  ST_ADDR: begin
                     if (sh_q[7:1] != TARGET_ADDR) begin
                        st_q <= ST_SKIP;
                     end else if (sh_q[0]) begin
                        st_q  <= ST_RDATA;   // read uses index from write
                        tx_q  <= 1'b1;
                        txb_q <= i_rdata;
                     end else begin
                        st_q <= ST_INDEX;
                     end
                  end
                  ST_INDEX: begin
                     idx_q <= sh_q;          // index byte
                     st_q  <= ST_WDATA;
                  end
                  ST_WDATA: begin
                     wr_q  <= 1'b1;          // data byte
                     wd_q  <= sh_q;
                  end
                  ST_RDATA: begin
                     tx_q <= 1'b1;           // index held for reads
                  end
                  default: begin
                     tx_q <= 1'b0;
                  end
               endcase
            end else begin
               bit_q <= bit_q + 4'h1;
               if (st_q == ST_RDATA) begin
                  txb_q <= {txb_q[6:0], 1'b0};
               end
            end
         end else if (wr_q) begin
            idx_q <= idx_q + 8'h01;          // auto increment on writes
         end
      end
   end

   assign o_acc.wr    = wr_q;
   assign o_acc.index = idx_q;
   assign o_acc.data  = wd_q;
   assign o_sda       = ack_q ? 1'b0 : txb_q[7];
   assign o_sda_oe    = ack_q || (tx_q && !txb_q[7]);   // open drain
endmodule : serial_target

// File: test/host_model.sv
/*
 * two-wire bus host model: drives scl and the host side of sda.
 * assumes a pull-up on sda, so the wire is low while either side pulls.
 */
module host_model
   import regbank_pkg::*;
(
   input  wire logic i_mclk,  // bench clock
   input  wire logic i_sda,   // resolved sda wire level
   output logic      o_scl,   // serial clock, idle high
   output logic      o_sda    // host sda, one releases the line
);
   timeunit 1ns;
   timeprecision 1ps;

   // both lines idle released
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end

   // half bit time, well above the two cycles the target needs
   task automatic q;
      repeat (5) @(negedge i_mclk);
   endtask : q

   // start; also a repeated start when entered with scl low
   task automatic start_c;
      o_sda = 1'b1;
      q();
      o_scl = 1'b1;
      q();
      o_sda = 1'b0;
      q();
      o_scl = 1'b0;
      q();
   endtask : start_c

   // stop: sda rises while scl is high
   task automatic stop_c;
      o_sda = 1'b0;
      q();
      o_scl = 1'b1;
      q();
      o_sda = 1'b1;
      q();
   endtask : stop_c

   // one clock pulse; sda held across it so no false start or stop
   task automatic pulse(output logic smp);
      q();
      o_scl = 1'b1;
      q();
      smp = i_sda;
      o_scl = 1'b0;
   endtask : pulse

   // send a byte msb first, then sample the acknowledge
   task automatic tx(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         o_sda = b[i];
         pulse(s);
      end
      o_sda = 1'b1;  // released so the target may pull
      pulse(s);
      ack = ~s;
      q();
   endtask : tx

   // receive a byte; last byte is not acknowledged
   task automatic rx(output logic [7:0] b, input logic last);
      logic s;
      o_sda = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         pulse(b[i]);
      end
      q();
      o_sda = last;
      pulse(s);     // ninth pulse carries the host's own ack bit
   endtask : rx

   // address, index, then one or two data bytes; ok when all acked
   task automatic wr_seq(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d0,
                         input logic [7:0] d1, input int n, output logic ok);
      logic k;
      start_c();
      tx({a, 1'b0}, k);
      ok = k;
      tx(idx, k);
      ok &= k;
      tx(d0, k);
      ok &= k;
      if (n > 1) begin
         tx(d1, k);
         ok &= k;
      end
      stop_c();
   endtask : wr_seq

   // index write phase first, then a two byte read
   task automatic rd_seq(input logic [7:0] idx, output logic [7:0] b0, output logic [7:0] b1);
      logic k;
      start_c();
      tx({TARGET_ADDR, 1'b0}, k);
      tx(idx, k);
      start_c();
      tx({TARGET_ADDR, 1'b1}, k);
      rx(b0, 1'b0);
      rx(b1, 1'b1);
      stop_c();
   endtask : rd_seq
endmodule : host_model

// File: test/tb_top.sv
/*
 * self-checking bench of the register bank: serial reads and writes.
 * assumes the host model and an nvm that answers one cycle after its address.
 */
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_fail++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top
   import regbank_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [7:0] NV_VER  = 8'h5a;  // nvm version word
   localparam logic [7:0] NV_MODE = 8'h0b;  // forced pwm, pin gating, soft enable
   localparam logic [7:0] NV_LIM  = 8'h2a;  // limit code 5, ramp code 2
   localparam logic [7:0] NV_ID   = 8'h03;  // identity modifier

   logic       mclk     = 1'b0;
   logic       rst      = 1'b1;
   logic       pin      = 1'b0;   // external rail enable
   logic [7:0] nvm_data = 8'h00;
   logic       scl, host_sda, dut_sda, dut_oe, config_done, ok;
   logic [1:0] nvm_addr_d = 2'h0;  // nvm address seen one cycle earlier
   logic [1:0] nvm_addr;
   rail_ctrl_t rail0;
   wire logic  sda_wire;
   int         n_fail   = 0;
   int         compares = 0;
   logic [7:0] t_idx [7] = '{OFS_IDENTITY, OFS_NVM_VERSION, OFS_RAIL0_MODE, OFS_RAIL0_LIMIT,
                             8'h0c, OFS_TOP_STATUS, OFS_LOAD_LOW};
   logic [7:0] t_exp [7] = '{{PART_IDENTITY ^ NV_ID[1:0], RST_IDENT_LOW[5:0]}, NV_VER,
                             RST_RAIL0_MODE | NV_MODE, NV_LIM, RST_ZERO, 8'ha5, 8'h7e};

   // pull-up: low while the host pulls or the target drives a zero
   assign sda_wire = host_sda & (dut_sda | ~dut_oe);

   always #10 mclk = ~mclk;

   // nvm answers one cycle after its address, driven off the sampling edge
   always @(negedge mclk) begin
      nvm_addr_d <= nvm_addr;
      case (nvm_addr_d)
         NVM_IDX_VERSION: nvm_data <= NV_VER;
         NVM_IDX_MODE:    nvm_data <= NV_MODE;
         NVM_IDX_LIMIT:   nvm_data <= NV_LIM;
         default:         nvm_data <= NV_ID;
      endcase
   end

   rail_regbank rail_regbank_i (
      .i_mclk(mclk), .i_rst(rst), .i_scl(scl), .i_sda(sda_wire), .o_sda(dut_sda),
      .o_sda_oe(dut_oe), .i_rail0_en_pin(pin), .o_nvm_addr(nvm_addr),
      .i_nvm_data(nvm_data), .o_config_done(config_done), .o_rail0(rail0),
      .i_status_top(8'ha5), .i_status_rail(8'h3c), .i_load_low(8'h7e), .i_load_high(8'h81));

   host_model host_model_i (.i_mclk(mclk), .i_sda(sda_wire), .o_scl(scl), .o_sda(host_sda));

   // prints counts and verdict, then ends the run
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test

   // read twice in one transfer: both bytes come from the same index
   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] ex);
      logic [7:0] b0, b1;
      host_model_i.rd_seq(idx, b0, b1);
      `CHK($sformatf("reg %h", idx), ex, b0)
      `CHK($sformatf("reg %h again", idx), ex, b1)
   endtask : rd_chk

   task automatic test_done(input string nm);
      $display("test %s done", nm);
   endtask : test_done

   // main sequence
   initial begin
      repeat (4) @(posedge mclk);
      @(negedge mclk) rst = 1'b0;
      for (int i = 0; i < 100 && config_done !== 1'b1; i++) @(negedge mclk);
      `CHK("config done", 1'b1, config_done)
      // nvm loaded values, read only bytes, unmapped and live bytes
      for (int i = 0; i < 7; i++) rd_chk(t_idx[i], t_exp[i]);
      `CHK("rail0", {NV_MODE[3], 1'b1, 1'b0, NV_LIM[5:0]}, rail0)
      pin = 1'b1;
      repeat (3) @(negedge mclk);
      `CHK("rail0", {NV_MODE[3], 1'b1, 1'b1, NV_LIM[5:0]}, rail0)
      test_done("nvm load");
      // burst write across two bytes; reserved limit code while running
      pin = 1'b0;
      host_model_i.wr_seq(TARGET_ADDR, OFS_RAIL0_MODE, 8'h01, 8'h3f, 2, ok);
      `CHK("write ack", 1'b1, ok)
      `CHK("rail0", {3'b001, 3'h7, 3'h7}, rail0)
      rd_chk(OFS_RAIL0_LIMIT, 8'h3f);
      test_done("burst");
      // writes to the identity and version bytes have no effect
      host_model_i.wr_seq(TARGET_ADDR, OFS_IDENTITY, 8'hff, 8'h00, 2, ok);
      rd_chk(OFS_IDENTITY, t_exp[0]);
      rd_chk(OFS_NVM_VERSION, NV_VER);
      test_done("read only");
      // foreign address is refused, then forced pwm with rail off
      host_model_i.wr_seq(7'h60, OFS_RAIL0_MODE, 8'h08, 8'h00, 1, ok);
      `CHK("foreign ack", 1'b0, ok)
      `CHK("rail0", {3'b001, 3'h7, 3'h7}, rail0)
      host_model_i.wr_seq(TARGET_ADDR, OFS_RAIL0_MODE, 8'h08, 8'h00, 1, ok);
      `CHK("rail0", {3'b100, 3'h7, 3'h7}, rail0)
      test_done("address");
      end_of_test();
   end

   // watchdog, far beyond the roughly seven thousand cycles expected
   initial begin
      repeat (40000) @(posedge mclk);
      n_fail++;
      $display("Error watchdog expected finish seen timeout");
      end_of_test();
   end
endmodule : tb_top
